// ### spc_byte_rx.sv
// Purpose: Synchronise serial pins and assemble bytes within a frame
// Assumes: Serial clock well below a quarter of the system clock, mode 0
// Notes:   Frame end reports whether a whole number of bytes arrived
`timescale 1ns/1ps
module spc_byte_rx
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Serial pins
    input  wire logic       cs_b_pin,
    input  wire logic       sck_pin,
    input  wire logic       si_pin,
    // Byte stream
    output logic            start_ff,
    output logic            byte_vld_ff,
    output logic [7:0]      byte_ff,
    output logic            end_ff,
    output logic            aligned_ff
);

    logic       cs_s1_ff;
    logic       cs_s2_ff;
    logic       cs_s3_ff;
    logic       sck_s1_ff;
    logic       sck_s2_ff;
    logic       sck_s3_ff;
    logic       si_s1_ff;
    logic       si_s2_ff;
    logic [2:0] bit_cnt_ff;
    logic [6:0] shift_ff;
    logic       sck_rise;

    // Stage one feeds only stage two
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cs_s1_ff  <= 1'b1;
            cs_s2_ff  <= 1'b1;
            cs_s3_ff  <= 1'b1;
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_s3_ff <= 1'b0;
            si_s1_ff  <= 1'b0;
            si_s2_ff  <= 1'b0;
        end
        else
        begin
            cs_s1_ff  <= cs_b_pin;
            cs_s2_ff  <= cs_s1_ff;
            cs_s3_ff  <= cs_s2_ff;
            sck_s1_ff <= sck_pin;
            sck_s2_ff <= sck_s1_ff;
            sck_s3_ff <= sck_s2_ff;
            si_s1_ff  <= si_pin;
            si_s2_ff  <= si_s1_ff;
        end
    end

    assign sck_rise = sck_s2_ff & ~sck_s3_ff & ~cs_s2_ff;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_cnt_ff  <= 3'h0;
            shift_ff    <= 7'h00;
            byte_ff     <= 8'h00;
            byte_vld_ff <= 1'b0;
        end
        else
        begin
            byte_vld_ff <= 1'b0;
            if (cs_s2_ff)
            begin
                bit_cnt_ff <= 3'h0;
            end
            else if (sck_rise)
            begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                shift_ff   <= {shift_ff[5:0], si_s2_ff};
                if (bit_cnt_ff == 3'h7)
                begin
                    byte_ff     <= {shift_ff, si_s2_ff};
                    byte_vld_ff <= 1'b1;
                end
            end
        end
    end

    // Frame edges; alignment is judged on the count at the rise of select
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            start_ff   <= 1'b0;
            end_ff     <= 1'b0;
            aligned_ff <= 1'b0;
        end
        else
        begin
            start_ff <= ~cs_s2_ff & cs_s3_ff;
            end_ff   <= cs_s2_ff & ~cs_s3_ff;
            if (cs_s2_ff & ~cs_s3_ff)
            begin
                aligned_ff <= (bit_cnt_ff == 3'h0);
            end
        end
    end

endmodule

// ### spc_host_model.sv
// Purpose: Serial host that frames flash commands, mode 0
// Assumes: Serial clock high for four system clocks and low for eight
// Notes:   Data line shows the inverse of its last bit outside frames
`timescale 1ns/1ps
module spc_host_model
(
    // Clock
    input  wire logic clock,
    // Serial pins
    output logic      cs_b_pin,
    output logic      sck_pin,
    output logic      si_pin
);
    initial
    begin
        cs_b_pin = 1'b1;
        sck_pin  = 1'b0;
        si_pin   = 1'b1;
    end

    task automatic frame(input logic [7:0] q[$], input int nbits);
        int i;
        @(negedge clock);
        cs_b_pin = 1'b0;
        for (i = 0; i < nbits; i++)
        begin
            repeat (4) @(negedge clock);
            si_pin = q[i / 8][7 - i % 8];
            repeat (4) @(negedge clock);
            sck_pin = 1'b1;
            repeat (4) @(negedge clock);
            sck_pin = 1'b0;
        end
        repeat (4) @(negedge clock);
        cs_b_pin = 1'b1;
        // Stale data must not look valid once the frame is over
        si_pin = ~si_pin;
    endtask
endmodule

// ### spc_pkg.sv
// Purpose: Shared constants for the sector protection control block
// Assumes: Serial commands arrive as bytes, most significant bit first
// Notes:   Sector index is taken from the top byte of the 24-bit address
package spc_pkg;

    localparam int          SPC_ADDR_W        = 24;
    localparam int          SPC_SECT_LSB      = 16;
    localparam int          SPC_SECT_W        = SPC_ADDR_W - SPC_SECT_LSB;
    localparam int          SPC_NUM_SECT      = 1 << SPC_SECT_W;
    localparam int          SPC_ADDR_BYTES    = 3;

    localparam logic [7:0]  SPC_OP_WR_ENABLE  = 8'h06;
    localparam logic [7:0]  SPC_OP_WR_DISABLE = 8'h04;
    localparam logic [7:0]  SPC_OP_PROTECT    = 8'h36;
    localparam logic [7:0]  SPC_OP_UNPROTECT  = 8'h39;
    localparam logic [7:0]  SPC_OP_WR_STAT1   = 8'h01;

    localparam int          SPC_LOCK_POS      = 7;
    localparam int          SPC_GLB_HI        = 5;
    localparam int          SPC_GLB_LO        = 2;
    localparam logic [3:0]  SPC_GLB_ONES      = 4'hf;
    localparam logic [3:0]  SPC_GLB_ZEROS     = 4'h0;
    localparam int          SPC_STAT_WP_POS   = 4;
    localparam int          SPC_STAT_SP_HI    = 3;
    localparam int          SPC_STAT_SP_LO    = 2;
    localparam int          SPC_STAT_LATCH_POS = 1;

    localparam logic [1:0]  SPC_SP_NONE       = 2'h0;
    localparam logic [1:0]  SPC_SP_SOME       = 2'h1;
    localparam logic [1:0]  SPC_SP_ALL        = 2'h3;

    localparam logic        SPC_LOCK_RST      = 1'b0;
    localparam logic        SPC_LATCH_RST     = 1'b0;
    localparam logic        SPC_SECT_RST      = 1'b1;

    typedef enum logic [2:0]
    {
        SPC_IDLE   = 3'h0,
        SPC_OPCODE = 3'h1,
        SPC_ADDR   = 3'h3,
        SPC_DATA   = 3'h5,
        SPC_DRAIN  = 3'h2
    } spc_state_t;

endpackage

// ### spc_sector_prot.sv
// Purpose: Per-sector write protection, lock bit and global protect decode
// Assumes: Suspend flag comes from same-clock program and erase logic
// Notes:   Serial pins are synchronised inside the byte receiver
`timescale 1ns/1ps
module spc_sector_prot
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    // Serial pins
    input  wire logic                     cs_b_pin,
    input  wire logic                     sck_pin,
    input  wire logic                     si_pin,
    // Write-protect pin, active low
    input  wire logic                     wp_b_pin,
    // Program and erase engine
    input  wire logic                     suspend_any,
    // Protection state
    output logic [SPC_NUM_SECT-1:0]       sector_protect_ff,
    output logic                          protection_lock_bit_ff,
    output logic                          write_latch_bit_ff,
    output logic [7:0]                    status_byte1_ff
);

    logic                   start;
    logic                   byte_vld;
    logic [7:0]             byte_data;
    logic                   frame_end;
    logic                   aligned;
    logic                   wp_s1_ff;
    logic                   wp_s2_ff;
    spc_state_t             state_ff;
    spc_state_t             nxt_state;
    logic [7:0]             cmd_ff;
    logic [1:0]             addr_cnt_ff;
    logic [SPC_ADDR_W-1:0]  sector_address_bits_ff;
    logic [7:0]             data_ff;
    logic                   data_seen_ff;

    function automatic logic [1:0] prot_summary(input logic [SPC_NUM_SECT-1:0] bits);
        logic [1:0] res;
        res = SPC_SP_SOME;
        if (&bits)
        begin
            res = SPC_SP_ALL;
        end
        else if (~|bits)
        begin
            res = SPC_SP_NONE;
        end
        return res;
    endfunction

    function automatic logic is_sector_cmd(input logic [7:0] op);
        return (op == SPC_OP_PROTECT) || (op == SPC_OP_UNPROTECT);
    endfunction

    spc_byte_rx u_rx
    (
        .clock       (clock),
        .rst_b       (rst_b),
        .cs_b_pin    (cs_b_pin),
        .sck_pin     (sck_pin),
        .si_pin      (si_pin),
        .start_ff    (start),
        .byte_vld_ff (byte_vld),
        .byte_ff     (byte_data),
        .end_ff      (frame_end),
        .aligned_ff  (aligned)
    );

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_s1_ff <= 1'b0;
            wp_s2_ff <= 1'b0;
        end
        else
        begin
            wp_s1_ff <= wp_b_pin;
            wp_s2_ff <= wp_s1_ff;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            SPC_IDLE:
            begin
                if (start)
                begin
                    nxt_state = SPC_OPCODE;
                end
            end
            SPC_OPCODE:
            begin
                if (byte_vld)
                begin
                    if (is_sector_cmd(byte_data))
                    begin
                        nxt_state = SPC_ADDR;
                    end
                    else if (byte_data == SPC_OP_WR_STAT1)
                    begin
                        nxt_state = SPC_DATA;
                    end
                    else
                    begin
                        nxt_state = SPC_DRAIN;
                    end
                end
            end
            SPC_ADDR:
            begin
                if (byte_vld && addr_cnt_ff == 2'(SPC_ADDR_BYTES - 1))
                begin
                    nxt_state = SPC_DRAIN;
                end
            end
            SPC_DATA:
            begin
                if (byte_vld)
                begin
                    nxt_state = SPC_DRAIN;
                end
            end
            SPC_DRAIN:
            begin
                nxt_state = SPC_DRAIN;
            end
            default:
            begin
                nxt_state = SPC_IDLE;
            end
        endcase
        // Frame end always returns to idle, whatever was in flight
        if (frame_end)
        begin
            nxt_state = SPC_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= SPC_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Command capture for the current frame
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_ff                 <= 8'h00;
            addr_cnt_ff            <= 2'h0;
            sector_address_bits_ff <= '0;
            data_ff                <= 8'h00;
            data_seen_ff           <= 1'b0;
        end
        else if (start)
        begin
            cmd_ff       <= 8'h00;
            addr_cnt_ff  <= 2'h0;
            data_seen_ff <= 1'b0;
        end
        else if (byte_vld)
        begin
            case (state_ff)
                SPC_OPCODE:
                begin
                    cmd_ff <= byte_data;
                end
                SPC_ADDR:
                begin
                    sector_address_bits_ff <= {sector_address_bits_ff[SPC_ADDR_W-9:0],
                                               byte_data};
                    addr_cnt_ff            <= addr_cnt_ff + 2'h1;
                end
                SPC_DATA:
                begin
                    data_ff      <= byte_data;
                    data_seen_ff <= 1'b1;
                end
                default:
                begin
                    cmd_ff <= cmd_ff;
                end
            endcase
        end
    end

    // Decode of a finished frame
    logic                    fin_wren;
    logic                    fin_wrdi;
    logic                    fin_sect;
    logic                    sect_ok;
    logic                    fin_stat;
    logic [3:0]              glb_field;
    logic                    glb_set;
    logic                    glb_clr;
    logic                    stat_allowed;
    logic [SPC_SECT_W-1:0]   sect_idx;

    always_comb
    begin
        fin_wren     = frame_end && aligned && cmd_ff == SPC_OP_WR_ENABLE;
        fin_wrdi     = frame_end && aligned && cmd_ff == SPC_OP_WR_DISABLE;
        fin_sect     = frame_end && is_sector_cmd(cmd_ff) && write_latch_bit_ff;
        sect_ok      = aligned && addr_cnt_ff == 2'(SPC_ADDR_BYTES) &&
                       !protection_lock_bit_ff;
        fin_stat     = frame_end && aligned && data_seen_ff &&
                       cmd_ff == SPC_OP_WR_STAT1 && write_latch_bit_ff;
        glb_field    = data_ff[SPC_GLB_HI:SPC_GLB_LO];
        stat_allowed = !protection_lock_bit_ff || wp_s2_ff;
        glb_set      = fin_stat && !protection_lock_bit_ff && glb_field == SPC_GLB_ONES;
        glb_clr      = fin_stat && !protection_lock_bit_ff && glb_field == SPC_GLB_ZEROS;
        sect_idx     = sector_address_bits_ff[SPC_ADDR_W-1:SPC_SECT_LSB];
    end

    // Write latch; sector commands consume it, a status write only once its data byte arrives aligned
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            write_latch_bit_ff <= SPC_LATCH_RST;
        end
        else if (fin_wren)
        begin
            write_latch_bit_ff <= 1'b1;
        end
        else if (fin_wrdi || fin_sect || fin_stat)
        begin
            write_latch_bit_ff <= 1'b0;
        end
    end

    // Lock bit; global protect-all pattern during suspend aborts the whole write
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            protection_lock_bit_ff <= SPC_LOCK_RST;
        end
        else if (fin_stat && stat_allowed && !(glb_set && suspend_any))
        begin
            protection_lock_bit_ff <= data_ff[SPC_LOCK_POS];
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sector_protect_ff <= {SPC_NUM_SECT{SPC_SECT_RST}};
        end
        else if (glb_set && !suspend_any)
        begin
            sector_protect_ff <= {SPC_NUM_SECT{1'b1}};
        end
        else if (glb_clr)
        begin
            sector_protect_ff <= '0;
        end
        else if (fin_sect && sect_ok)
        begin
            sector_protect_ff[sect_idx] <= (cmd_ff == SPC_OP_PROTECT);
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_byte1_ff <= 8'h00;
        end
        else
        begin
            status_byte1_ff                                  <= 8'h00;
            status_byte1_ff[SPC_LOCK_POS]                    <= protection_lock_bit_ff;
            status_byte1_ff[SPC_STAT_WP_POS]                 <= wp_s2_ff;
            status_byte1_ff[SPC_STAT_SP_HI:SPC_STAT_SP_LO]   <= prot_summary(sector_protect_ff);
            status_byte1_ff[SPC_STAT_LATCH_POS]              <= write_latch_bit_ff;
        end
    end

endmodule

// ### spc_sector_prot_props.sv
// Purpose: Concurrent checks on the sector protection ports
// Assumes: Chip select stays high for at least four clocks between frames
// Notes:   Status byte lags the protection state by one clock
`timescale 1ns/1ps
module spc_prot_props
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    // Frame pin
    input  wire logic                     cs_b_pin,
    // Protection state
    input  wire logic [SPC_NUM_SECT-1:0]  sector_protect_ff,
    input  wire logic                     protection_lock_bit_ff,
    input  wire logic                     write_latch_bit_ff,
    input  wire logic [7:0]               status_byte1_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    chk_sect_at_end: assert property (!$stable(sector_protect_ff) |-> $past(cs_b_pin, 3))
        else $error("sector bits changed inside a frame");
    chk_sect_needs_latch: assert property
        (!$stable(sector_protect_ff) |-> $past(write_latch_bit_ff) && !write_latch_bit_ff)
        else $error("sector bits changed without the write latch");
    chk_lock_freeze: assert property
        ($past(protection_lock_bit_ff) |-> $stable(sector_protect_ff))
        else $error("sector bits changed while locked");
    chk_lock_needs_latch: assert property
        (!$stable(protection_lock_bit_ff) |-> $past(write_latch_bit_ff) && !write_latch_bit_ff)
        else $error("lock bit changed without the write latch");
    chk_latch_at_end: assert property ($rose(write_latch_bit_ff) |-> $past(cs_b_pin, 3))
        else $error("write latch set inside a frame");
    chk_status_mirror: assert property
        (status_byte1_ff[SPC_LOCK_POS] == $past(protection_lock_bit_ff) &&
         status_byte1_ff[SPC_STAT_LATCH_POS] == $past(write_latch_bit_ff))
        else $error("status byte does not mirror lock and latch");
    // Status still holds its reset value on the first clock after release
    chk_sum_all: assert property
        ($past(rst_b) && $past(&sector_protect_ff) |->
         status_byte1_ff[SPC_STAT_SP_HI:SPC_STAT_SP_LO] == SPC_SP_ALL)
        else $error("summary does not show all protected");
    chk_sum_none: assert property
        ($past(rst_b) && $past(~|sector_protect_ff) |->
         status_byte1_ff[SPC_STAT_SP_HI:SPC_STAT_SP_LO] == SPC_SP_NONE)
        else $error("summary does not show none protected");
    chk_one_sector: assert property
        (!$stable(sector_protect_ff) && (|sector_protect_ff) && !(&sector_protect_ff) |->
         $onehot(sector_protect_ff ^ $past(sector_protect_ff)))
        else $error("sector command touched more than one bit");
    chk_spare_zero: assert property (status_byte1_ff[6:5] == 2'h0 && !status_byte1_ff[0])
        else $error("spare status bits not zero");
endmodule

bind spc_sector_prot spc_prot_props u_spc_prot_props
(
    .clock                  (clock),
    .rst_b                  (rst_b),
    .cs_b_pin               (cs_b_pin),
    .sector_protect_ff      (sector_protect_ff),
    .protection_lock_bit_ff (protection_lock_bit_ff),
    .write_latch_bit_ff     (write_latch_bit_ff),
    .status_byte1_ff        (status_byte1_ff)
);

// ### tb_top.sv
// Purpose: Self-checking bench for sector protection control
// Assumes: Integer model updated at every frame end
// Notes:   Results are compared twelve clocks after chip select rises
`timescale 1ns/1ps
module tb_top;
    import spc_pkg::*;
    logic                    clock;
    logic                    rst_b;
    logic                    cs_b_pin;
    logic                    sck_pin;
    logic                    si_pin;
    logic                    wp_b_pin;
    logic                    suspend_any;
    logic [SPC_NUM_SECT-1:0] sector_protect_ff;
    logic                    protection_lock_bit_ff;
    logic                    write_latch_bit_ff;
    logic [7:0]              status_byte1_ff;
    logic [7:0]              q[$];
    logic [7:0]              dtab[9] = '{8'h7f, 8'h7f, 8'h00, 8'hff, 8'h0f, 8'hf0, 8'h0f,
                                         8'hf0, 8'h0f};
    logic [1:0]              ctab[9] = '{2'h3, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2,
                                         2'h2, 2'h2};
    int                      fail_count;
    int                      cmp_count;
    int                      lock_m;
    int                      latch_m;
    logic [23:0]             addr_v;
    int                      k;
    int                      sect_m[SPC_NUM_SECT];

    always #4 clock = ~clock;

    spc_sector_prot u_spc_sector_prot
    (
        .clock(clock), .rst_b(rst_b), .cs_b_pin(cs_b_pin), .sck_pin(sck_pin),
        .si_pin(si_pin), .wp_b_pin(wp_b_pin), .suspend_any(suspend_any),
        .sector_protect_ff(sector_protect_ff), .protection_lock_bit_ff(protection_lock_bit_ff),
        .write_latch_bit_ff(write_latch_bit_ff), .status_byte1_ff(status_byte1_ff)
    );

    spc_host_model u_spc_host_model
    (
        .clock(clock), .cs_b_pin(cs_b_pin), .sck_pin(sck_pin), .si_pin(si_pin)
    );

    task automatic cmp_sect(input logic [SPC_NUM_SECT-1:0] got,
                            input logic [SPC_NUM_SECT-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch sectors at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch byte at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_all();
        logic [SPC_NUM_SECT-1:0] e;
        logic [1:0]              s;
        for (int i = 0; i < SPC_NUM_SECT; i++)
            e[i] = sect_m[i][0];
        s = (&e) ? SPC_SP_ALL : ((|e) ? SPC_SP_SOME : SPC_SP_NONE);
        cmp_sect(sector_protect_ff, e);
        cmp8(status_byte1_ff, {lock_m[0], 2'h0, wp_b_pin, s, latch_m[0], 1'b0});
        cmp8({6'h0, protection_lock_bit_ff, write_latch_bit_ff},
             {6'h0, lock_m[0], latch_m[0]});
    endtask

    task automatic model(input logic [7:0] qq[$], input int nbits);
        int         nb;
        logic [7:0] dt;
        nb = nbits / 8;
        dt = (qq.size() > 1) ? qq[1] : 8'h00;
        if (nbits % 8 != 0 && qq[0] != SPC_OP_PROTECT && qq[0] != SPC_OP_UNPROTECT)
            return;
        if (qq[0] == SPC_OP_WR_ENABLE)
            latch_m = 1;
        else if (qq[0] == SPC_OP_WR_DISABLE)
            latch_m = 0;
        else if ((qq[0] == SPC_OP_PROTECT || qq[0] == SPC_OP_UNPROTECT) && latch_m == 1)
        begin
            if (lock_m == 0 && nbits % 8 == 0 && nb >= 4)
                sect_m[dt] = (qq[0] == SPC_OP_PROTECT);
            latch_m = 0;
        end
        else if (qq[0] == SPC_OP_WR_STAT1 && nb >= 2 && latch_m == 1)
        begin
            latch_m = 0;
            if (lock_m == 1 && wp_b_pin === 1'b1)
                lock_m = dt[7];
            else if (lock_m == 0 && !(dt[5:2] == SPC_GLB_ONES && suspend_any))
            begin
                lock_m = dt[7];
                for (int i = 0; i < SPC_NUM_SECT; i++)
                    if (dt[5:2] == SPC_GLB_ONES || dt[5:2] == SPC_GLB_ZEROS)
                        sect_m[i] = (dt[5:2] == SPC_GLB_ONES);
            end
        end
    endtask

    task automatic run(input logic [7:0] qq[$], input int nbits);
        u_spc_host_model.frame(qq, nbits);
        model(qq, nbits);
        repeat (12) @(negedge clock);
        check_all();
    endtask

    task automatic sect_cmd(input logic [7:0] op, input int nbits, input bit keep = 1'b0);
        // Keeping the address lets a protect undo the unprotect just made
        if (!keep)
            addr_v = 24'($urandom);
        run('{SPC_OP_WR_ENABLE}, 8);
        run('{op, addr_v[23:16], addr_v[15:8], addr_v[7:0], 8'($urandom)}, nbits);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        k = $urandom(32'h6444398f);
        clock = 1'b0;
        rst_b = 1'b0;
        wp_b_pin = 1'b1;
        suspend_any = 1'b0;
        lock_m = 0;
        latch_m = 0;
        foreach (sect_m[i])
            sect_m[i] = 1;
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        repeat (8) @(negedge clock);
        check_all();
        run('{SPC_OP_WR_ENABLE}, 8);
        run('{SPC_OP_WR_STAT1}, 8);
        run('{SPC_OP_WR_DISABLE}, 8);
        run('{SPC_OP_WR_ENABLE, 8'h00}, 12);
        run('{SPC_OP_UNPROTECT, 8'h12, 8'h34, 8'h56}, 32);
        sect_cmd(SPC_OP_UNPROTECT, 40, 1'b0);
        sect_cmd(SPC_OP_PROTECT, 32, 1'b1);
        sect_cmd(SPC_OP_UNPROTECT, 24);
        sect_cmd(SPC_OP_UNPROTECT, 30);
        // Each pattern is followed by a sector command to mix global and single updates
        for (k = 0; k < 9; k++)
        begin
            wp_b_pin = ctab[k][1];
            suspend_any = ctab[k][0];
            run('{SPC_OP_WR_ENABLE}, 8);
            run('{SPC_OP_WR_STAT1, dtab[k]}, 16);
            sect_cmd(k[0] ? SPC_OP_PROTECT : SPC_OP_UNPROTECT, 32);
        end
        for (k = 0; k < 8; k++)
        begin
            wp_b_pin = 1'($urandom);
            suspend_any = 1'($urandom);
            run('{SPC_OP_WR_ENABLE}, 8);
            run('{SPC_OP_WR_STAT1, 8'($urandom)}, 16);
            sect_cmd(8'($urandom) < 8'h80 ? SPC_OP_PROTECT : SPC_OP_UNPROTECT, 32);
        end
        results();
    end

    initial
    begin
        repeat (90000) @(posedge clock);
        fail_count++;
        results();
    end
endmodule
